/* File: rtl/readout_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef READOUT_REGS_SVH
`define READOUT_REGS_SVH
`define REG_DEV_ID_ADDR   7'h40
`define REG_CTRL_ADDR     7'h55
`define DEV_ID_MSB        6
`define SEL_MSB           7
`define SEL_LSB           6
`define DEV_ID_RST        8'h50
`define CTRL_RST          8'h00
`define SEL_OFF           2'h0
`define SEL_FULL          2'h3
`define EE_FIRST          7'h00
`define EE_LAST           7'h7f
`define CFG_FIRST         7'h40
`define CFG_LAST          7'h61
`define SEND01_FIRST      7'h5b
`define SEND11_FIRST      7'h40
`define SEND_LAST         7'h3f
`define CLK_PERIOD_NS     10.0
`define RO_FAST_PERIOD_NS 780.0
`define RO_SLOW_PERIOD_US 3.125
`define RO_FAST_CYC       (int'(`RO_FAST_PERIOD_NS / `CLK_PERIOD_NS))
`define RO_SLOW_CYC       (int'(`RO_SLOW_PERIOD_US * 1000.0 / `CLK_PERIOD_NS))
`define BIT_SLOTS         5'd18
`define FRAME_LAST_SLOT   5'd19
`define FIFO_DEPTH        16
`define BYTE_W            8
`endif

/* File: rtl/readout_pkg.sv */
// Types shared by the configuration readout logic
`default_nettype none
package readout_pkg;
   typedef enum logic [2:0] {
      ST_BOOT,
      ST_NORMAL,
      ST_TM_LOAD,
      ST_TM_SEND,
      ST_TM_HOLD,
      ST_EXIT_LOAD
   } seq_state_t;
endpackage
`default_nettype wire

/* File: rtl/byte_fifo.sv */
// Synchronous FIFO between the EEPROM reader and the Manchester sender
`timescale 1ns/1ns
`default_nettype none
`include "readout_regs.svh"
module byte_fifo #(
   parameter int WIDTH = `BYTE_W,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   // Depth must be a power of two; the extra pointer bit tells full from empty
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      wr_d;
   logic [AW:0]      rd_q;
   logic [AW:0]      rd_d;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem_q[rd_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      if (flush) begin
         wr_d = '0;
         rd_d = '0;
      end else begin
         if (push) wr_d = wr_q + 1'b1;
         if (pop) rd_d = rd_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push && !flush) mem_q[wr_q[AW-1:0]] <= in_data;
   end

   property p_fill_bound;
      @(posedge core_clk) disable iff (rst)
         (AW+1)'(wr_q - rd_q) <= (AW+1)'(DEPTH);
   endproperty
   a_fill_bound: assert property (p_fill_bound)
      else $error("FIFO fill level above depth");
endmodule
`default_nettype wire

/* File: rtl/manchester_tx.sv */
// Readout clock divider and Manchester byte-frame sender for the sink
`timescale 1ns/1ns
`default_nettype none
`include "readout_regs.svh"
module manchester_tx #(
   parameter int FAST_CYC = `RO_FAST_CYC,
   parameter int SLOW_CYC = `RO_SLOW_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       abort,
   input  wire logic       fast_readout_rate,
   input  wire logic       in_valid,
   input  wire logic [7:0] in_data,
   output logic            in_ready,
   output logic            sink_on,
   output logic            busy
);
   localparam logic [8:0] FAST_L = 9'(FAST_CYC - 1);
   localparam logic [8:0] SLOW_L = 9'(SLOW_CYC - 1);
   logic       busy_q;
   logic       busy_d;
   logic [8:0] div_q;
   logic [8:0] div_d;
   logic [4:0] slot_q;
   logic [4:0] slot_d;
   logic [8:0] shift_q;
   logic [8:0] shift_d;
   logic       sink_q;
   logic       sink_d;
   logic       tick;
   logic [3:0] bit_idx;

   assign tick     = busy_q && (div_q >= (fast_readout_rate ? FAST_L : SLOW_L));
   assign in_ready = !busy_q && !abort;
   assign sink_on  = sink_q;
   assign busy     = busy_q;

   always_comb begin
      busy_d  = busy_q;
      div_d   = div_q;
      slot_d  = slot_q;
      shift_d = shift_q;
      if (abort) begin
         busy_d = 1'b0;
      end else if (in_valid && in_ready) begin
         busy_d  = 1'b1;
         div_d   = '0;
         slot_d  = '0;
         shift_d = {1'b1, in_data};
      end else if (tick) begin
         div_d = '0;
         if (slot_q == `FRAME_LAST_SLOT) busy_d = 1'b0;
         else slot_d = slot_q + 5'd1;
      end else if (busy_q) begin
         div_d = div_q + 9'd1;
      end
      // Start bit first, then data most significant bit first
      bit_idx = 4'd8 - slot_d[4:1];
      // One bit is on then off, zero bit off then on; pause keeps sink off
      sink_d  = busy_d && (slot_d < `BIT_SLOTS) && (shift_d[bit_idx] ^ slot_d[0]);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy_q  <= 1'b0;
         div_q   <= '0;
         slot_q  <= '0;
         shift_q <= '0;
         sink_q  <= 1'b0;
      end else begin
         busy_q  <= busy_d;
         div_q   <= div_d;
         slot_q  <= slot_d;
         shift_q <= shift_d;
         sink_q  <= sink_d;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_mid_flip;
      busy_q && tick && !abort && !slot_q[0] && (slot_q < `BIT_SLOTS)
         |=> sink_on != $past(sink_on);
   endproperty
   a_mid_flip: assert property (p_mid_flip)
      else $error("No transition in the middle of a bit");

   property p_start_on;
      in_valid && in_ready |=> sink_on && busy;
   endproperty
   a_start_on: assert property (p_start_on)
      else $error("Start bit does not open with the sink on");

   property p_pause_off;
      busy_q && (slot_q >= `BIT_SLOTS) |-> !sink_on;
   endproperty
   a_pause_off: assert property (p_pause_off)
      else $error("Sink on during the frame pause");

   property p_div_step;
      busy_q && !tick && !abort && !in_ready |=> div_q == $past(div_q) + 9'd1;
   endproperty
   a_div_step: assert property (p_div_step)
      else $error("Readout divider did not advance");

   property p_abort;
      abort |=> !busy && !sink_on;
   endproperty
   a_abort: assert property (p_abort)
      else $error("Frame not stopped on abort");
endmodule
`default_nettype wire

/* File: rtl/config_readout_manchester.sv */
// Test-mode control, EEPROM reload and configuration readout on the alarm pin
`timescale 1ns/1ns
`default_nettype none
`include "readout_regs.svh"
module config_readout_manchester #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter int FAST_CYC   = `RO_FAST_CYC,
   parameter int SLOW_CYC   = `RO_SLOW_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       entry_cmp_async,
   input  wire logic       exit_cmp_async,
   input  wire logic       fast_readout_rate,
   output logic            ee_req,
   output logic      [6:0] ee_dev_id,
   output logic      [6:0] ee_addr,
   input  wire logic       ee_ack,
   input  wire logic [7:0] ee_rdata,
   output logic            sink_on,
   output logic            test_mode,
   output logic            cfg_loading,
   output logic            normal_run,
   output logic      [7:0] eeprom_bus_identifier,
   output logic      [1:0] test_mode_select
);
   readout_pkg::seq_state_t state_q;
   readout_pkg::seq_state_t state_d;
   logic [6:0] addr_q;
   logic [6:0] addr_d;
   logic [6:0] last_q;
   logic [6:0] last_d;
   logic       req_q;
   logic       req_d;
   logic [7:0] dev_q;
   logic [7:0] dev_d;
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [1:0] sel;
   logic       in_tm;
   logic       rd_ack;
   logic       last_hit;
   logic       abort;
   logic       reading;
   logic       push;
   logic       fifo_in_ready;
   logic       fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic       tx_in_ready;
   logic       entry_s;
   logic       exit_s;

   // Pin comparator levels: three stages, change accepted when last two agree
   logic [1:0] async_in;
   logic [2:0] sync_q [2];
   logic [1:0] lvl_q;
   logic [1:0] lvl_d;
   assign async_in = {exit_cmp_async, entry_cmp_async};

   for (genvar gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
         if (rst) sync_q[gi] <= 3'h0;
         else sync_q[gi] <= {sync_q[gi][1:0], async_in[gi]};
      end
      assign lvl_d[gi] = (sync_q[gi][1] == sync_q[gi][2]) ? sync_q[gi][1]
                                                          : lvl_q[gi];
   end

   always_ff @(posedge core_clk) begin
      if (rst) lvl_q <= 2'h0;
      else lvl_q <= lvl_d;
   end

   assign entry_s = lvl_q[0];
   assign exit_s  = lvl_q[1];

   assign sel      = ctrl_q[`SEL_MSB:`SEL_LSB];
   assign in_tm    = (state_q == readout_pkg::ST_TM_LOAD) ||
                     (state_q == readout_pkg::ST_TM_SEND) ||
                     (state_q == readout_pkg::ST_TM_HOLD);
   assign rd_ack   = req_q && ee_ack;
   assign last_hit = addr_q == last_q;
   assign reading  = (state_q == readout_pkg::ST_BOOT) ||
                     (state_q == readout_pkg::ST_TM_LOAD) ||
                     (state_q == readout_pkg::ST_TM_SEND) ||
                     (state_q == readout_pkg::ST_EXIT_LOAD);
   assign push     = rd_ack && (state_q == readout_pkg::ST_TM_SEND) && !abort;

   always_comb begin
      state_d = state_q;
      addr_d  = addr_q;
      last_d  = last_q;
      req_d   = req_q;
      dev_d   = dev_q;
      ctrl_d  = ctrl_q;
      abort   = 1'b0;
      // One read outstanding; the sender's FIFO room throttles readout reads
      if (reading && !req_q &&
          (state_q != readout_pkg::ST_TM_SEND || fifo_in_ready)) begin
         req_d = 1'b1;
      end
      if (rd_ack) begin
         req_d  = 1'b0;
         addr_d = addr_q + 7'd1;
         if (state_q != readout_pkg::ST_TM_SEND) begin
            if (addr_q == `REG_DEV_ID_ADDR) dev_d = ee_rdata;
            if (addr_q == `REG_CTRL_ADDR) ctrl_d = ee_rdata;
         end
      end
      case (state_q)
         readout_pkg::ST_BOOT: begin
            if (rd_ack && last_hit) state_d = readout_pkg::ST_NORMAL;
         end
         readout_pkg::ST_NORMAL: begin
            if (sel[0] && entry_s && !exit_s) begin
               state_d = readout_pkg::ST_TM_LOAD;
               addr_d  = `CFG_FIRST;
               last_d  = `CFG_LAST;
            end
         end
         readout_pkg::ST_TM_LOAD: begin
            if (rd_ack && last_hit) begin
               // Select may have changed with the re-read; use fresh value
               if (ctrl_d[`SEL_LSB]) begin
                  state_d = readout_pkg::ST_TM_SEND;
                  addr_d  = (ctrl_d[`SEL_MSB:`SEL_LSB] == `SEL_FULL)
                            ? `SEND11_FIRST : `SEND01_FIRST;
                  last_d  = `SEND_LAST;
               end else begin
                  state_d = readout_pkg::ST_TM_HOLD;
               end
            end
         end
         readout_pkg::ST_TM_SEND: begin
            if (rd_ack && last_hit) state_d = readout_pkg::ST_TM_HOLD;
         end
         readout_pkg::ST_TM_HOLD: begin
            state_d = readout_pkg::ST_TM_HOLD;
         end
         readout_pkg::ST_EXIT_LOAD: begin
            if (rd_ack && last_hit) state_d = readout_pkg::ST_NORMAL;
         end
         default: begin
            state_d = readout_pkg::ST_BOOT;
            addr_d  = `EE_FIRST;
            last_d  = `EE_LAST;
            req_d   = 1'b0;
         end
      endcase
      // Leaving test mode beats the request and state steps above, including a pending read; register captures still take effect
      if (in_tm && exit_s) begin
         abort = 1'b1;
         req_d = 1'b0;
         if (sel == `SEL_OFF) begin
            state_d = readout_pkg::ST_NORMAL;
         end else begin
            state_d = readout_pkg::ST_EXIT_LOAD;
            addr_d  = (sel == `SEL_FULL) ? `EE_FIRST : `CFG_FIRST;
            last_d  = (sel == `SEL_FULL) ? `EE_LAST : `CFG_LAST;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= readout_pkg::ST_BOOT;
         addr_q  <= `EE_FIRST;
         last_q  <= `EE_LAST;
         req_q   <= 1'b0;
         dev_q   <= `DEV_ID_RST;
         ctrl_q  <= `CTRL_RST;
      end else begin
         state_q <= state_d;
         addr_q  <= addr_d;
         last_q  <= last_d;
         req_q   <= req_d;
         dev_q   <= dev_d;
         ctrl_q  <= ctrl_d;
      end
   end

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .flush     (abort),
      .in_valid  (push),
      .in_data   (ee_rdata),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (tx_in_ready)
   );

   manchester_tx #(
      .FAST_CYC (FAST_CYC),
      .SLOW_CYC (SLOW_CYC)
   ) u_tx (
      .core_clk          (core_clk),
      .rst               (rst),
      .abort             (abort),
      .fast_readout_rate (fast_readout_rate),
      .in_valid          (fifo_out_valid),
      .in_data           (fifo_out_data),
      .in_ready          (tx_in_ready),
      .sink_on           (sink_on),
      .busy              ()
   );

   assign ee_req                = req_q;
   assign ee_addr               = addr_q;
   assign ee_dev_id             = dev_q[`DEV_ID_MSB:0];
   assign eeprom_bus_identifier = dev_q;
   assign test_mode_select      = sel;
   assign test_mode             = in_tm;
   assign cfg_loading           = (state_q == readout_pkg::ST_BOOT) ||
                                  (state_q == readout_pkg::ST_TM_LOAD) ||
                                  (state_q == readout_pkg::ST_EXIT_LOAD);
   // Select 00 or 10 keeps the device running normally in ST_TM_HOLD, after the re-read
   assign normal_run = (state_q == readout_pkg::ST_NORMAL) ||
                       (state_q == readout_pkg::ST_TM_HOLD && !sel[0]);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_exit_seen;
      in_tm && exit_s;
   endsequence

   sequence s_reread_begins;
      (state_q == readout_pkg::ST_TM_LOAD) && (addr_q == `CFG_FIRST)
         ##1 (ee_req || !in_tm);
   endsequence

   property p_entry;
      !in_tm ##1 in_tm |-> $past(ctrl_q[`SEL_LSB]) && $past(entry_s);
   endproperty
   a_entry: assert property (p_entry)
      else $error("Test mode entered without select bit or pin level");

   property p_reread_first;
      $rose(in_tm) |-> s_reread_begins;
   endproperty
   a_reread_first: assert property (p_reread_first)
      else $error("Test mode did not start with an EEPROM re-read");

   property p_exit;
      s_exit_seen |=> !in_tm && !sink_on && !ee_req;
   endproperty
   a_exit: assert property (p_exit)
      else $error("Test mode or transfer not ended on exit level");

   property p_keep;
      s_exit_seen and (sel == `SEL_OFF) |=>
         (state_q == readout_pkg::ST_NORMAL) && !cfg_loading;
   endproperty
   a_keep: assert property (p_keep)
      else $error("Reload started although select was zero");

   property p_reload;
      // A 0x40 read finishing in the exit cycle already counts, unless it is a send read
      s_exit_seen and (sel != `SEL_OFF) |=>
         (state_q == readout_pkg::ST_EXIT_LOAD) &&
         (ee_dev_id == $past(dev_d[`DEV_ID_MSB:0])) ##1 ee_req;
   endproperty
   a_reload: assert property (p_reload)
      else $error("Reload not started from stored identifier");

   property p_range_full;
      s_exit_seen and (sel == `SEL_FULL) |=>
         (addr_q == `EE_FIRST) && (last_q == `EE_LAST);
   endproperty
   a_range_full: assert property (p_range_full)
      else $error("Full reload range wrong");

   property p_range_short;
      s_exit_seen and ((sel != `SEL_FULL) && (sel != `SEL_OFF)) |=>
         (addr_q == `CFG_FIRST) && (last_q == `CFG_LAST);
   endproperty
   a_range_short: assert property (p_range_short)
      else $error("Short reload range wrong");

   property p_capture;
      rd_ack && (state_q != readout_pkg::ST_TM_SEND) &&
         (addr_q == `REG_CTRL_ADDR) |=>
         test_mode_select == $past(ee_rdata[`SEL_MSB:`SEL_LSB]);
   endproperty
   a_capture: assert property (p_capture)
      else $error("Test mode select not taken from its register");

   property p_send_start;
      (state_q == readout_pkg::ST_TM_LOAD) && rd_ack && last_hit && !exit_s
         |=> ($past(ctrl_d[`SEL_LSB])
              ? (state_q == readout_pkg::ST_TM_SEND && last_q == `SEND_LAST)
              : (state_q == readout_pkg::ST_TM_HOLD && normal_run));
   endproperty
   a_send_start: assert property (p_send_start)
      else $error("Wrong action after test-mode re-read");
endmodule
`default_nettype wire

/* File: test/pin_tester.sv */
// External tester model: drives the pin levels and decodes the sink current
`timescale 1ns/1ns
`default_nettype none
module pin_tester #(
   parameter int FAST_CYC = 4,
   parameter int SLOW_CYC = 6
) (
   input  wire logic core_clk,
   input  wire logic pin_raise,
   input  wire logic fast_readout_rate,
   input  wire logic sink_on,
   output logic      entry_cmp_async,
   output logic      exit_cmp_async
);
   logic [7:0]  rx_q[$];
   int          bad_halves = 0;
   int          cnt = 0;
   int          half = 0;
   int          per = 0;
   int          pz = 0;
   logic        busy_q = 1'b0;
   logic        prev_q = 1'b0;
   logic [17:0] sh_q = '0;
   logic [17:0] w;
   logic [7:0]  b;
   // Hysteresis is not modelled: the pin is either well above or below
   assign entry_cmp_async = pin_raise;
   assign exit_cmp_async  = ~pin_raise;
   always @(posedge core_clk) begin
      prev_q <= sink_on;
      if (pz > 0) begin
         pz <= pz - 1;
         if (pz <= 2 * per - 2 && sink_on)
            bad_halves = bad_halves + 1;
      end
      if (!pin_raise) begin
         busy_q <= 1'b0;
         pz <= 0;
      end else if (!busy_q) begin
         // Align on the rising current of the start bit
         if (sink_on && !prev_q) begin
            busy_q <= 1'b1;
            per <= fast_readout_rate ? FAST_CYC : SLOW_CYC;
            cnt <= (fast_readout_rate ? FAST_CYC : SLOW_CYC) / 2;
            half <= 0;
         end
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         // Sample mid-half; every half, the first one included, lasts per cycles
         sh_q[17 - half] <= sink_on;
         half <= half + 1;
         cnt <= per;
         if (half == 17) begin
            w = {sh_q[17:1], sink_on};
            busy_q <= 1'b0;
            pz <= 5 * per / 2;
            if (!w[17])
               bad_halves = bad_halves + 1;
            for (int k = 0; k < 9; k++) begin
               if (w[17 - 2 * k] == w[16 - 2 * k])
                  bad_halves = bad_halves + 1;
            end
            for (int k = 1; k < 9; k++) begin
               b[8 - k] = w[17 - 2 * k];
            end
            rx_q.push_back(b);
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/test_config_readout_manchester.sv */
// Testbench: EEPROM responder, pin tester and test-mode scenarios
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_config_readout_manchester;
   localparam int FC = 4;
   localparam int SC = 6;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        pin_raise = 1'b0;
   logic        fast = 1'b1;
   logic        ee_ack = 1'b0;
   logic [7:0]  ee_rdata = 8'h00;
   logic        wait_q = 1'b0;
   logic        sink_seen = 1'b0;
   wire logic   entry_cmp;
   wire logic   exit_cmp;
   logic        ee_req;
   logic [6:0]  ee_dev_id;
   logic [6:0]  ee_addr;
   logic        sink_on;
   logic        test_mode;
   logic        cfg_loading;
   logic        normal_run;
   logic [7:0]  dev_reg;
   logic [1:0]  sel;
   logic [7:0]  mem[128];
   logic [13:0] rd_q[$];
   int          bad_count = 0;
   int          compares = 0;

   always #5 core_clk = ~core_clk;

   config_readout_manchester #(.FIFO_DEPTH(16), .FAST_CYC(FC), .SLOW_CYC(SC))
   dut (.core_clk(core_clk), .rst(rst), .entry_cmp_async(entry_cmp),
      .exit_cmp_async(exit_cmp), .fast_readout_rate(fast), .ee_req(ee_req),
      .ee_dev_id(ee_dev_id), .ee_addr(ee_addr), .ee_ack(ee_ack),
      .ee_rdata(ee_rdata), .sink_on(sink_on), .test_mode(test_mode),
      .cfg_loading(cfg_loading), .normal_run(normal_run),
      .eeprom_bus_identifier(dev_reg), .test_mode_select(sel));

   pin_tester #(.FAST_CYC(FC), .SLOW_CYC(SC)) tester (.core_clk(core_clk),
      .pin_raise(pin_raise), .fast_readout_rate(fast), .sink_on(sink_on),
      .entry_cmp_async(entry_cmp), .exit_cmp_async(exit_cmp));

   // EEPROM: acks in the third cycle of a request; data invalid otherwise
   always @(posedge core_clk) begin
      if (sink_on)
         sink_seen <= 1'b1;
      if (ee_ack) begin
         if (ee_req)
            rd_q.push_back({ee_dev_id, ee_addr});
         ee_ack <= 1'b0;
         wait_q <= 1'b0;
         ee_rdata <= ~ee_rdata;
      end else if (ee_req && wait_q) begin
         ee_ack <= 1'b1;
         ee_rdata <= mem[ee_addr];
      end else begin
         wait_q <= ee_req;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wait_done;
      for (int i = 0; i < 4000; i++) begin
         if (normal_run === 1'b1 && cfg_loading === 1'b0)
            break;
         cyc(1);
      end
   endtask

   task automatic wait_rx(input int n);
      for (int i = 0; i < 4000 && tester.rx_q.size() < n; i++)
         cyc(1);
   endtask

   task automatic chk_reads(input logic [6:0] first, input int n,
                            input logic [6:0] dev);
      `CHK("read count", 1'b1, rd_q.size() >= n)
      for (int i = 0; i < n && i < rd_q.size(); i++)
         `CHK("read", {dev, 7'(first + 7'(i))}, rd_q[i])
   endtask

   task automatic enter;
      pin_raise <= 1'b1;
      for (int i = 0; i < 20 && test_mode !== 1'b1; i++)
         cyc(1);
      `CHK("test_mode in", 1'b1, test_mode)
      `CHK("loading", 1'b1, cfg_loading)
   endtask

   task automatic leave;
      pin_raise <= 1'b0;
      cyc(1);
      for (int i = 0; i < 8 && test_mode !== 1'b0; i++)
         cyc(1);
      `CHK("test_mode out", 1'b0, test_mode)
      `CHK("sink off", 1'b0, sink_on)
      rd_q.delete();
   endtask

   task automatic t_boot;
      for (int a = 0; a < 128; a++)
         mem[a] = 8'(a * 37 + 11);
      mem[8'h40] = 8'h50;
      mem[8'h55] = 8'h40;
      cyc(16);
      `CHK("id reset", 8'h50, dev_reg)
      `CHK("sel reset", 2'h0, sel)
      rst <= 1'b0;
      wait_done();
      chk_reads(7'h00, 128, 7'h50);
      `CHK("sel", 2'h1, sel)
   endtask

   task automatic t_send_fast;
      rd_q.delete();
      enter();
      wait_rx(3);
      chk_reads(7'h40, 34, 7'h50);
      `CHK("send start", 7'h5b, rd_q[34][6:0])
      // FIFO full holds back the reader while the slow sender drains it
      `CHK("backlog", 1'b1, rd_q.size() inside {[52:56]})
      for (int i = 0; i < 3; i++)
         `CHK("byte", mem[8'h5b + i], tester.rx_q[i])
      `CHK("halves", 0, tester.bad_halves)
      leave();
      wait_done();
      `CHK("reload n", 34, rd_q.size())
      chk_reads(7'h40, 34, 7'h50);
   endtask

   task automatic t_send_slow;
      mem[8'h55] = 8'hc0;
      mem[8'h40] = 8'h2a;
      fast <= 1'b0;
      tester.rx_q.delete();
      enter();
      wait_rx(2);
      `CHK("sel 3", 2'h3, sel)
      `CHK("byte0", 8'h2a, tester.rx_q[0])
      `CHK("byte1", mem[8'h41], tester.rx_q[1])
      `CHK("halves", 0, tester.bad_halves)
      for (int i = 0; i < 200 && sink_on !== 1'b1; i++)
         cyc(1);
      leave();
      wait_done();
      `CHK("reload n", 128, rd_q.size())
      chk_reads(7'h00, 128, 7'h2a);
      `CHK("id", 8'h2a, dev_reg)
   endtask

   // Select 10 after the re-read: run normally, then a short reload on exit
   task automatic t_hold_ten;
      mem[8'h55] = 8'h80;
      enter();
      wait_done();
      `CHK("sel 2", 2'h2, sel)
      `CHK("ten run", 1'b1, normal_run)
      `CHK("ten mode", 1'b1, test_mode)
      mem[8'h55] = 8'h40;
      leave();
      wait_done();
      `CHK("ten reload n", 34, rd_q.size())
      chk_reads(7'h40, 34, 7'h2a);
   endtask

   task automatic t_hold;
      mem[8'h55] = 8'h00;
      enter();
      wait_done();
      sink_seen <= 1'b0;
      cyc(200);
      `CHK("hold mode", 1'b1, test_mode)
      `CHK("hold run", 1'b1, normal_run)
      `CHK("hold sink", 1'b0, sink_seen)
      `CHK("sel 0", 2'h0, sel)
      leave();
      cyc(300);
      `CHK("no reload", 0, rd_q.size())
      `CHK("run", 1'b1, normal_run)
   endtask

   task automatic t_no_entry;
      pin_raise <= 1'b1;
      cyc(30);
      `CHK("no entry", 1'b0, test_mode)
      pin_raise <= 1'b0;
      cyc(5);
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Whole run is a few thousand cycles; this limit leaves a wide margin
   initial begin
      cyc(30000);
      bad_count++;
      end_sim();
   end

   initial begin
      t_boot();
      t_send_fast();
      t_send_slow();
      t_hold_ten();
      t_hold();
      t_no_entry();
      end_sim();
   end
endmodule
`default_nettype wire
